// File: src/acc_datapath_defs.vh
// constants for the accumulator datapath: offsets, fields, reset values, clip values
`ifndef ACC_DATAPATH_DEFS_VH
`define ACC_DATAPATH_DEFS_VH

// register byte offsets
`define OFS_CORE_CTRL 8'h00
`define OFS_TRAP_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_WB_PTR 8'h0C
`define OFS_FIRST_ACC_LO 8'h10
`define OFS_FIRST_ACC_HI 8'h14
`define OFS_SECOND_ACC_LO 8'h18
`define OFS_SECOND_ACC_HI 8'h1C
`define OFS_SHIFT_LO 8'h20
`define OFS_SHIFT_HI 8'h24

// core control fields
`define CC_ROUND_MODE_BIT 1
`define CC_STORE_CLIP_BIT 3
`define CC_CLIP_WIDTH_BIT 4
`define CC_CLIP_EN_LO 6
`define CC_CLIP_EN_HI 7

// trap control fields
`define TC_FIRST_GUARD_BIT 0
`define TC_SECOND_GUARD_BIT 1
`define TC_CATASTROPHIC_BIT 2

// status fields
`define ST_FIRST_GUARD_BIT 0
`define ST_SECOND_GUARD_BIT 1
`define ST_FIRST_CLIP_BIT 2
`define ST_SECOND_CLIP_BIT 3
`define ST_ANY_GUARD_BIT 4
`define ST_ANY_CLIP_BIT 5
`define ST_TRAP_BIT 6

// reset values
`define CORE_CTRL_RESET 8'h00
`define TRAP_CTRL_RESET 3'h0
`define WB_PTR_RESET 16'h0000

// store target modes
`define ST_MODE_ADDR 2'd0
`define ST_MODE_PTR_DIRECT 2'd1
`define ST_MODE_PTR_INDIRECT 2'd2

// clip values and write-back pointer step
`define CLIP39_POS 40'h7F_FFFF_FFFF
`define CLIP39_NEG 40'h80_0000_0000
`define CLIP31_POS 40'h00_7FFF_FFFF
`define CLIP31_NEG 40'hFF_8000_0000
`define WORD_POS_MAX 16'h7FFF
`define WORD_NEG_MAX 16'h8000
`define WB_PTR_STEP 16'h0002

`endif

// File: src/acc_datapath.v
// accumulator back end: 40-bit adder, clipping, rounding, store clipping, shifter
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "acc_datapath_defs.vh"

module acc_datapath #(
    parameter ACC_W = 40,
    parameter PROD_W = 33
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // adder request from sequencer
    input wire op_valid,
    input wire op_acc_sel,
    input wire op_subtract,
    input wire op_zero_acc,
    input wire op_src_shift,
    input wire [PROD_W-1:0] product_in,
    // store and write-back request
    input wire st_valid,
    input wire st_acc_sel,
    input wire st_round,
    input wire st_mac_wb,
    input wire [1:0] st_mode,
    input wire [15:0] st_addr,
    // shifter request
    input wire sh_valid,
    input wire [1:0] sh_src,
    input wire sh_arith,
    input wire sh_dsp,
    input wire signed [5:0] sh_amount,
    input wire [15:0] xbus_rd_data,
    // data space write
    output reg xbus_wr_en,
    output reg [15:0] xbus_wr_addr,
    output reg [15:0] xbus_wr_data,
    // results and flags
    output reg [15:0] mcu_shift_result,
    output reg arith_trap_req,
    output wire any_guard_ovf_flag,
    output wire any_clip_flag
);

    reg [ACC_W-1:0] first_accumulator_q;
    reg [ACC_W-1:0] second_accumulator_q;
    reg [ACC_W-1:0] shift_q;
    reg [15:0] writeback_pointer_reg_q;
    reg [7:0] core_control_reg_q;
    reg [2:0] trap_control_reg_q;
    reg first_acc_guard_ovf_flag_q;
    reg second_acc_guard_ovf_flag_q;
    reg first_acc_clip_flag_q;
    reg second_acc_clip_flag_q;
    wire [1:0] per_acc_clip_enable = core_control_reg_q[`CC_CLIP_EN_HI:`CC_CLIP_EN_LO];
    wire clip_width_sel = core_control_reg_q[`CC_CLIP_WIDTH_BIT];
    wire store_clip_enable = core_control_reg_q[`CC_STORE_CLIP_BIT];
    wire round_mode_sel = core_control_reg_q[`CC_ROUND_MODE_BIT];
    // all bits of a slice agree
    function uniform9;
        input [8:0] v;
        begin
            uniform9 = (&v) | ~(|v);
        end
    endfunction
    // ---------------- barrel shifter ----------------
    reg [ACC_W-1:0] sh_in;
    reg [ACC_W-1:0] shift_val;
    reg [4:0] sh_mag;
    reg sh_right;
    wire [5:0] sh_neg = -sh_amount;
    always @* begin
        sh_right = ~sh_amount[5];
        sh_mag = sh_amount[5] ? sh_neg[4:0] : sh_amount[4:0];
        if (sh_src == 2'd0) begin
            sh_in = first_accumulator_q;
        end else if (sh_src == 2'd1) begin
            sh_in = second_accumulator_q;
        end else if (sh_right) begin
            sh_in = {{8{sh_arith & xbus_rd_data[15]}}, xbus_rd_data, 16'h0000};
        end else begin
            sh_in = {{24{sh_arith & xbus_rd_data[15]}}, xbus_rd_data};
        end
        if (sh_mag == 5'd0) begin
            shift_val = sh_in;
        end else if (sh_right) begin
            if (sh_arith) begin
                shift_val = $signed(sh_in) >>> sh_mag;
            end else begin
                shift_val = sh_in >> sh_mag;
            end
        end else begin
            shift_val = sh_in << sh_mag;
        end
    end

    // ---------------- adder ----------------
    // accumulator source and sign extension
    wire [ACC_W-1:0] acc_cur = op_acc_sel ? second_accumulator_q : first_accumulator_q;
    wire [ACC_W-1:0] b_in = op_src_shift ? shift_val :
        {{(ACC_W-PROD_W){product_in[PROD_W-1]}}, product_in};
    wire [ACC_W-1:0] a_op = op_zero_acc ? {ACC_W{1'b0}} : acc_cur;
    wire [ACC_W-1:0] b_op = op_subtract ? ~b_in : b_in;
    // carry-in high for subtract means no borrow
    wire [ACC_W:0] sum_full = {1'b0, a_op} + {1'b0, b_op} + {{ACC_W{1'b0}}, op_subtract};
    wire [ACC_W-1:0] sum = sum_full[ACC_W-1:0];
    wire ovf39 = (a_op[39] == b_op[39]) & (sum[39] != a_op[39]);
    wire guard_raw = ~((&sum[39:32]) | ~(|sum[39:32]));
    wire ovf31 = ovf39 | ~uniform9(sum[39:31]);
    wire true_neg = ovf39 ? ~sum[39] : sum[39];
    reg [ACC_W-1:0] acc_next;
    reg guard_next;
    reg clip_hit;
    reg clip_en_sel;
    always @* begin
        clip_en_sel = per_acc_clip_enable[op_acc_sel];
        acc_next = sum;
        guard_next = guard_raw;
        clip_hit = 1'b0;
        if (clip_en_sel & ~clip_width_sel) begin
            // bit 31 mode, guard flag held clear
            guard_next = 1'b0;
            clip_hit = ovf31;
            if (ovf31) begin
                acc_next = true_neg ? `CLIP31_NEG : `CLIP31_POS;
            end
        end else if (clip_en_sel) begin
            // width select one picks bit 39 mode
            clip_hit = ovf39;
            if (ovf39) begin
                acc_next = true_neg ? `CLIP39_NEG : `CLIP39_POS;
            end
        end else begin
            clip_hit = ovf39;
        end
    end
    // ---------------- round and store clipping ----------------
    reg [ACC_W-1:0] st_acc;
    reg st_do_round;
    reg round_inc;
    reg [23:0] st_wide;
    reg [15:0] st_word;
    always @* begin
        if (st_mac_wb) begin
            st_acc = op_acc_sel ? first_accumulator_q : second_accumulator_q;
        end else begin
            st_acc = st_acc_sel ? second_accumulator_q : first_accumulator_q;
        end
        st_do_round = st_round | st_mac_wb;
        round_inc = 1'b0;
        if (st_do_round) begin
            if (round_mode_sel & (st_acc[15:0] == 16'h8000)) begin
                round_inc = st_acc[16];
            end else begin
                // low word 0x8000 and up rounds up
                round_inc = st_acc[15];
            end
        end
        st_wide = st_acc[39:16] + {23'h000000, round_inc};
        st_word = st_wide[15:0];
        if (store_clip_enable) begin
            if (~st_acc[39] & (st_wide[23:15] != 9'h000)) begin
                st_word = `WORD_POS_MAX;
            end else if (st_acc[39] & (st_wide[23:15] != 9'h1FF)) begin
                st_word = `WORD_NEG_MAX;
            end
        end
    end

    // ---------------- apb decode ----------------
    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pwrite;
    reg [31:0] rd_mux;
    reg rd_hit;
    assign pready = psel & penable;
    assign any_guard_ovf_flag = first_acc_guard_ovf_flag_q | second_acc_guard_ovf_flag_q;
    assign any_clip_flag = first_acc_clip_flag_q | second_acc_clip_flag_q;
    wire [6:0] status_word = {arith_trap_req, any_clip_flag, any_guard_ovf_flag,
        second_acc_clip_flag_q, first_acc_clip_flag_q,
        second_acc_guard_ovf_flag_q, first_acc_guard_ovf_flag_q};
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == `OFS_CORE_CTRL) begin
            rd_mux = {24'h00_0000, core_control_reg_q};
        end else if (paddr == `OFS_TRAP_CTRL) begin
            rd_mux = {29'h0000_0000, trap_control_reg_q};
        end else if (paddr == `OFS_STATUS) begin
            rd_mux = {25'h000_0000, status_word};
        end else if (paddr == `OFS_WB_PTR) begin
            rd_mux = {16'h0000, writeback_pointer_reg_q};
        end else if (paddr == `OFS_FIRST_ACC_LO) begin
            rd_mux = first_accumulator_q[31:0];
        end else if (paddr == `OFS_FIRST_ACC_HI) begin
            rd_mux = {24'h00_0000, first_accumulator_q[39:32]};
        end else if (paddr == `OFS_SECOND_ACC_LO) begin
            rd_mux = second_accumulator_q[31:0];
        end else if (paddr == `OFS_SECOND_ACC_HI) begin
            rd_mux = {24'h00_0000, second_accumulator_q[39:32]};
        end else if (paddr == `OFS_SHIFT_LO) begin
            rd_mux = shift_q[31:0];
        end else if (paddr == `OFS_SHIFT_HI) begin
            rd_mux = {24'h00_0000, shift_q[39:32]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read data and error captured in setup, stable through access
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~rd_hit;
        end
    end

    wire wr_core = apb_write & (paddr == `OFS_CORE_CTRL);
    wire wr_trap = apb_write & (paddr == `OFS_TRAP_CTRL);
    wire wr_status = apb_write & (paddr == `OFS_STATUS);
    wire wr_ptr = apb_write & (paddr == `OFS_WB_PTR);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_control_reg_q <= `CORE_CTRL_RESET;
            trap_control_reg_q <= `TRAP_CTRL_RESET;
        end else begin
            if (wr_core) begin
                core_control_reg_q <= pwdata[7:0];
            end
            if (wr_trap) begin
                trap_control_reg_q <= pwdata[2:0];
            end
        end
    end

    // ---------------- accumulators and flags ----------------
    wire op_first = op_valid & ~op_acc_sel;
    wire op_second = op_valid & op_acc_sel;
    wire sh_first = sh_valid & sh_dsp & ~op_valid & (sh_src != 2'd1);
    wire sh_second = sh_valid & sh_dsp & ~op_valid & (sh_src == 2'd1);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_accumulator_q <= {ACC_W{1'b0}};
            second_accumulator_q <= {ACC_W{1'b0}};
            first_acc_guard_ovf_flag_q <= 1'b0;
            second_acc_guard_ovf_flag_q <= 1'b0;
        end else begin
            // guard flag rewritten on every adder pass
            if (op_first) begin
                first_accumulator_q <= acc_next;
                first_acc_guard_ovf_flag_q <= guard_next;
            end else if (sh_first) begin
                first_accumulator_q <= shift_val;
            end
            if (op_second) begin
                second_accumulator_q <= acc_next;
                second_acc_guard_ovf_flag_q <= guard_next;
            end else if (sh_second) begin
                second_accumulator_q <= shift_val;
            end
        end
    end

    // sticky: hardware set beats software clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_acc_clip_flag_q <= 1'b0;
            second_acc_clip_flag_q <= 1'b0;
        end else begin
            if (op_first & clip_hit) begin
                first_acc_clip_flag_q <= 1'b1;
            end else if (wr_status & pwdata[`ST_FIRST_CLIP_BIT]) begin
                first_acc_clip_flag_q <= 1'b0;
            end
            if (op_second & clip_hit) begin
                second_acc_clip_flag_q <= 1'b1;
            end else if (wr_status & pwdata[`ST_SECOND_CLIP_BIT]) begin
                second_acc_clip_flag_q <= 1'b0;
            end
        end
    end

    // trap request from flags and enables
    // guard flag trap
    // catastrophic trap while clipping is off
    wire trap_next =
        (first_acc_guard_ovf_flag_q & trap_control_reg_q[`TC_FIRST_GUARD_BIT]) |
        (second_acc_guard_ovf_flag_q & trap_control_reg_q[`TC_SECOND_GUARD_BIT]) |
        (trap_control_reg_q[`TC_CATASTROPHIC_BIT] &
            ((first_acc_clip_flag_q & ~per_acc_clip_enable[0]) |
             (second_acc_clip_flag_q & ~per_acc_clip_enable[1])));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arith_trap_req <= 1'b0;
        end else begin
            arith_trap_req <= trap_next;
        end
    end

    // ---------------- shifter result ----------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= {ACC_W{1'b0}};
            mcu_shift_result <= 16'h0000;
        end else if (sh_valid) begin
            shift_q <= shift_val;
            mcu_shift_result <= sh_right ? shift_val[31:16] : shift_val[15:0];
        end
    end

    // ---------------- store and write-back ----------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xbus_wr_en <= 1'b0;
            xbus_wr_addr <= 16'h0000;
            xbus_wr_data <= 16'h0000;
            writeback_pointer_reg_q <= `WB_PTR_RESET;
        end else begin
            xbus_wr_en <= 1'b0;
            if (st_valid & (st_mode == `ST_MODE_PTR_DIRECT)) begin
                writeback_pointer_reg_q <= st_word;
            end else if (st_valid & (st_mode == `ST_MODE_PTR_INDIRECT)) begin
                xbus_wr_en <= 1'b1;
                xbus_wr_addr <= writeback_pointer_reg_q;
                xbus_wr_data <= st_word;
                writeback_pointer_reg_q <= writeback_pointer_reg_q + `WB_PTR_STEP;
            end else begin
                if (st_valid & (st_mode == `ST_MODE_ADDR)) begin
                    xbus_wr_en <= 1'b1;
                    xbus_wr_addr <= st_addr;
                    xbus_wr_data <= st_word;
                end
                if (wr_ptr) begin
                    writeback_pointer_reg_q <= pwdata[15:0];
                end
            end
        end
    end

endmodule // acc_datapath

// File: verif/xbus_mem_model.sv
// data space word memory seen across the x bus
`timescale 1ns/1ns
module xbus_mem_model (
    // clock
    input wire logic clk,
    // write side from the datapath
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    // read side toward the shifter
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic [15:0] wr_cnt
);
    logic [15:0] mem [256];
    initial begin
        foreach (mem[k]) mem[k] = 16'h0000;
        wr_cnt = 16'h0000;
    end
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr[8:1]] <= wr_data;
            wr_cnt <= wr_cnt + 16'h0001;
        end
    end
    assign rd_data = mem[rd_addr[8:1]];
endmodule // xbus_mem_model

// File: verif/acc_datapath_sva.sv
// port-level assertions for the accumulator datapath
`timescale 1ns/1ns
module acc_datapath_sva (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // watched ports
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire st_valid,
    input wire [1:0] st_mode,
    input wire sh_valid,
    input wire [1:0] sh_src,
    input wire sh_arith,
    input wire signed [5:0] sh_amount,
    input wire [15:0] xbus_rd_data,
    input wire op_valid,
    input wire xbus_wr_en,
    input wire [15:0] xbus_wr_data,
    input wire [15:0] mcu_shift_result,
    input wire arith_trap_req,
    input wire any_guard_ovf_flag,
    input wire any_clip_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [14:0] rd_lo = xbus_rd_data[14:0];
    wire [14:0] rd_hi = xbus_rd_data[15:1];
    sequence s_store;
        st_valid && st_mode != 2'd1;
    endsequence
    sequence s_wr;
        xbus_wr_en;
    endsequence
    property p_ready;
        pready == (psel && penable);
    endproperty
    a_ready: assert property (p_ready) else $error("pready mismatch");
    property p_store;
        s_store |=> s_wr;
    endproperty
    a_store: assert property (p_store) else $error("store gave no write");
    property p_ptr_direct;
        st_valid && st_mode == 2'd1 |=> !xbus_wr_en;
    endproperty
    a_ptr_direct: assert property (p_ptr_direct) else $error("direct store wrote bus");
    property p_data_hold;
        !xbus_wr_en |-> $stable(xbus_wr_data);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("write data moved");
    property p_clip_sticky;
        any_clip_flag && !(psel && penable && pwrite) |=> any_clip_flag;
    endproperty
    a_clip_sticky: assert property (p_clip_sticky) else $error("clip flag dropped");
    property p_trap_quiet;
        !any_guard_ovf_flag && !any_clip_flag |=> !arith_trap_req;
    endproperty
    a_trap_quiet: assert property (p_trap_quiet) else $error("trap without flag");
    property p_guard_cause;
        $rose(any_guard_ovf_flag) |-> $past(op_valid || sh_valid);
    endproperty
    a_guard_cause: assert property (p_guard_cause) else $error("guard flag uncaused");
    property p_sh_right;
        sh_valid && sh_src[1] && !sh_arith && sh_amount == 6'sd1
            |=> mcu_shift_result == {1'b0, $past(rd_hi)};
    endproperty
    a_sh_right: assert property (p_sh_right) else $error("right shift wrong");
    property p_sh_left;
        sh_valid && sh_src[1] && sh_amount == -6'sd1 |=> mcu_shift_result == {$past(rd_lo), 1'b0};
    endproperty
    a_sh_left: assert property (p_sh_left) else $error("left shift wrong");
endmodule // acc_datapath_sva

// File: verif/dsp_accumulator_datapath_test.sv
// self-checking bench for the accumulator datapath
`timescale 1ns/1ns
`include "acc_datapath_defs.vh"
module dsp_accumulator_datapath_test;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, op_valid, op_acc_sel, op_subtract;
    logic op_zero_acc, st_valid, st_round, st_mac_wb, sh_valid, sh_arith, sh_dsp, xbus_wr_en;
    logic arith_trap_req, any_guard_ovf_flag, any_clip_flag, e, op_src_shift, st_acc_sel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [32:0] product_in;
    logic [1:0] st_mode, sh_src;
    logic signed [5:0] sh_amount;
    logic [15:0] st_addr, xbus_rd_data, xbus_wr_addr, xbus_wr_data, mcu_shift_result, rd_addr;
    logic [15:0] wcnt;
    logic [39:0] v;
    int error_cnt = 0, n_compared = 0, i;
    logic [7:0] rt_cc [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h08, 8'h08, 8'h00};
    logic [32:0] rt_p [8] = '{33'h0_1235_8000, 33'h0_1235_8000, 33'h0_1235_7FFF, 33'h0_1234_8000,
        33'h0_1235_8000, 33'h0_9000_0000, 33'h1_7000_0000, 33'h1_7000_0000};
    logic rt_r [8] = '{0, 1, 1, 1, 1, 0, 0, 0};
    logic [15:0] rt_x [8] = '{16'h1235, 16'h1236, 16'h1235, 16'h1234, 16'h1236, 16'h7FFF,
        16'h8000, 16'h7000};
    logic signed [5:0] sa [6] = '{1, -1, 16, -16, 4, -4};
    logic [7:0] sm_cc [4] = '{8'h00, 8'h50, 8'h40, 8'h10};
    logic [32:0] sm_p [4] = '{33'h0_007F_FFFF, 33'h0_007F_FFFF, 33'h0_7FFF_FFFF, 33'h0_007F_FFFF};
    logic [32:0] sm_a [4] = '{33'h1_0000, 33'h1_0000, 33'h1, 33'h1_0000};
    logic [31:0] sm_hi [4] = '{32'h80, 32'h7F, 32'h00, 32'h80};
    logic [31:0] sm_lo [4] = '{32'h0, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0};
    logic [31:0] sm_st [4] = '{32'h35, 32'h35, 32'h24, 32'h35};
    acc_datapath dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .op_valid(op_valid), .op_acc_sel(op_acc_sel),
        .op_subtract(op_subtract), .op_zero_acc(op_zero_acc), .op_src_shift(op_src_shift),
        .product_in(product_in), .st_valid(st_valid), .st_acc_sel(st_acc_sel),
        .st_round(st_round),
        .st_mac_wb(st_mac_wb), .st_mode(st_mode), .st_addr(st_addr), .sh_valid(sh_valid),
        .sh_src(sh_src), .sh_arith(sh_arith), .sh_dsp(sh_dsp), .sh_amount(sh_amount),
        .xbus_rd_data(xbus_rd_data), .xbus_wr_en(xbus_wr_en), .xbus_wr_addr(xbus_wr_addr),
        .xbus_wr_data(xbus_wr_data), .mcu_shift_result(mcu_shift_result),
        .arith_trap_req(arith_trap_req), .any_guard_ovf_flag(any_guard_ovf_flag),
        .any_clip_flag(any_clip_flag));
    xbus_mem_model mem_u (.clk(clk), .wr_en(xbus_wr_en), .wr_addr(xbus_wr_addr),
        .wr_data(xbus_wr_data), .rd_addr(rd_addr), .rd_data(xbus_rd_data), .wr_cnt(wcnt));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [39:0] s, input logic [39:0] x);
        n_compared++;
        if (s !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(r, x);
    endtask
    task op(input logic s, input logic sub, input logic z, input logic [32:0] p);
        @(posedge clk);
        op_valid <= 1; op_acc_sel <= s; op_subtract <= sub; op_zero_acc <= z; product_in <= p;
        @(posedge clk);
        op_valid <= 0;
    endtask
    task st(input logic rnd, input logic mac, input logic [1:0] m);
        @(posedge clk);
        st_valid <= 1; st_round <= rnd; st_mac_wb <= mac; st_mode <= m; op_acc_sel <= mac;
        @(posedge clk);
        st_valid <= 0;
    endtask
    task sh(input logic [1:0] s, input logic ar, input logic d, input logic signed [5:0] a);
        @(posedge clk);
        sh_valid <= 1; sh_src <= s; sh_arith <= ar; sh_dsp <= d; sh_amount <= a;
        @(posedge clk);
        sh_valid <= 0;
        #1;
    endtask
    task mem_chk(input logic [15:0] a, input logic [15:0] x);
        rd_addr <= a;
        @(posedge clk);
        #1 chk(xbus_rd_data, x);
    endtask
    task wt;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, op_valid, op_acc_sel, op_subtract} = 0;
        {op_zero_acc, product_in, st_valid, st_round, st_mac_wb, st_mode} = 0;
        {sh_valid, sh_src, sh_arith, sh_dsp, sh_amount, op_src_shift, st_acc_sel} = 0;
        st_addr = 16'h0100; rd_addr = 16'h0000; rst_n = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1;
        for (i = 0; i < 4; i++) rd(i * 4, 32'h0000_0000);
        apb(0, 8'h28, 0);
        chk(e, 1'b1);
        for (i = 0; i < 8; i++) begin
            apb(1, `OFS_CORE_CTRL, rt_cc[i]);
            op(0, 0, 1, rt_p[i]);
            st(rt_r[i], 0, 0);
            mem_chk(16'h0100, rt_x[i]);
        end
        op(0, 0, 1, 33'h0_A5C3_0000);
        apb(1, `OFS_WB_PTR, 32'h0200);
        st(1, 1, 2);
        mem_chk(16'h0200, 16'hA5C3);
        chk(xbus_wr_addr, 16'h0200);
        rd(`OFS_WB_PTR, 32'h0202);
        st(1, 1, 1);
        rd(`OFS_WB_PTR, 32'hA5C3);
        chk(wcnt, 16'd9);
        for (i = 0; i < 6; i++) begin
            sh(2, 0, 0, sa[i]);
            if (sa[i] > 0) v = {8'h00, 16'hA5C3, 16'h0000} >> sa[i];
            else v = {24'h00_0000, 16'hA5C3} << (-sa[i]);
            chk(mcu_shift_result, (sa[i] > 0) ? v[31:16] : v[15:0]);
        end
        op(1, 0, 1, 33'h5);
        op(1, 1, 0, 33'h7);
        rd(`OFS_SECOND_ACC_LO, 32'hFFFF_FFFE);
        rd(`OFS_SECOND_ACC_HI, 32'hFF);
        // plain store from the second accumulator, truncated
        st_acc_sel <= 1;
        st(0, 0, 0);
        mem_chk(16'h0100, 16'hFFFF);
        {st_acc_sel, sh_src, sh_amount} <= 0;
        op_src_shift <= 1;
        op(1, 0, 0, 33'h0);
        op_src_shift <= 0;
        rd(`OFS_SECOND_ACC_LO, 32'hA5C2_FFFE);
        sh(1, 0, 1, 4);
        rd(`OFS_SECOND_ACC_LO, 32'h0A5C_2FFF);
        op(0, 0, 1, 33'h1_8000_0000);
        sh(0, 1, 1, 4);
        rd(`OFS_FIRST_ACC_HI, 32'hFF);
        rd(`OFS_FIRST_ACC_LO, 32'hF800_0000);
        op(0, 0, 1, 33'h1_8000_0000);
        sh(0, 0, 1, 4);
        rd(`OFS_FIRST_ACC_HI, 32'h0F);
        for (i = 0; i < 4; i++) begin
            apb(1, `OFS_CORE_CTRL, 0);
            apb(1, `OFS_STATUS, 32'h0C);
            op(0, 0, 1, sm_p[i]);
            if (i != 2) sh(0, 0, 1, -16);
            apb(1, `OFS_CORE_CTRL, sm_cc[i]);
            op(0, 0, 0, sm_a[i]);
            rd(`OFS_FIRST_ACC_HI, sm_hi[i]);
            rd(`OFS_FIRST_ACC_LO, sm_lo[i]);
            rd(`OFS_STATUS, sm_st[i]);
            chk(any_clip_flag, 1'b1);
            chk(any_guard_ovf_flag, (i != 2));
        end
        apb(1, `OFS_TRAP_CTRL, 1);
        wt;
        chk(arith_trap_req, 1'b1);
        apb(1, `OFS_TRAP_CTRL, 0);
        wt;
        chk(arith_trap_req, 1'b0);
        apb(1, `OFS_TRAP_CTRL, 4);
        wt;
        chk(arith_trap_req, 1'b1);
        apb(1, `OFS_STATUS, 32'h0C);
        op(0, 0, 1, 33'h0);
        wt;
        chk(arith_trap_req, 1'b0);
        rd(`OFS_STATUS, 32'h00);
        end_sim;
    end
    initial begin
        #(50 * 5000);
        error_cnt++;
        end_sim;
    end
endmodule // dsp_accumulator_datapath_test
bind acc_datapath acc_datapath_sva chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .st_valid(st_valid),
    .st_mode(st_mode), .sh_valid(sh_valid), .sh_src(sh_src), .sh_arith(sh_arith),
    .sh_amount(sh_amount), .xbus_rd_data(xbus_rd_data), .op_valid(op_valid),
    .xbus_wr_en(xbus_wr_en), .xbus_wr_data(xbus_wr_data), .mcu_shift_result(mcu_shift_result),
    .arith_trap_req(arith_trap_req), .any_guard_ovf_flag(any_guard_ovf_flag),
    .any_clip_flag(any_clip_flag));
